// [pkg/fwd_pkg.sv]
// package: forwarding engine register map, field positions and enumerations
package fwd_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_MAP_ADDR = 8'h20; // forward_port_map_ctl
	localparam logic [7:0] REG_MODE_ADDR = 8'h21; // forward_mode_ctl
	localparam logic [7:0] REG_STAT_ADDR = 8'h22; // forwarding sync status

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int DIS_LSB = 0; // port_forward_disable, one bit per receive port
	localparam int MAP_LSB = 4; // buffer to transmitter map, one bit per port
	localparam int SYNC_LSB = 2; // synchronized_mode_select, two bits per transmitter
	localparam int RR_LSB = 6; // round_robin_enable, one bit per transmitter
	localparam int STAT_SYNC_LSB = 0; // synced flag per transmitter
	localparam int STAT_LOST_LSB = 2; // sticky lost flag per transmitter

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] MAP_RST = 8'h00; // all buffers to transmitter 0, none disabled
	localparam logic [7:0] MODE_RST = 8'hC0; // round robin on, synchronized off

	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SYNC_OFF = 2'b00,
		SYNC_BASIC = 2'b01,
		SYNC_ILV = 2'b10,
		SYNC_CAT = 2'b11
	} sync_mode_e;

	typedef enum logic [1:0] {
		PK_FS = 2'b00,
		PK_FE = 2'b01,
		PK_LINE = 2'b10,
		PK_OTHER = 2'b11
	} pkt_kind_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DATA = 2'b01,
		ST_HUNT = 2'b10
	} eng_state_e;

endpackage

// [pkg/fwd_arb_if.sv]
// interface: request and grant between a scheduler and its round robin arbiter
`timescale 1ns/10ps
interface fwd_arb_if;
	logic [3:0] req; // ports with a whole packet waiting
	logic gnt_vld; // some port is granted
	logic [1:0] gnt_idx; // granted port
	logic take; // scheduler accepted the grant
	modport arb (input req, input take, output gnt_vld, output gnt_idx);
	modport eng (output req, output take, input gnt_vld, input gnt_idx);
endinterface

// [rtl/fwd_rr_arb.sv]
// module: round robin arbiter over the four receive ports
`timescale 1ns/10ps
module fwd_rr_arb (
	input wire logic i_clk, // device clock
	input wire logic i_rst_n, // asynchronous reset, active low
	fwd_arb_if.arb arb_port // request and grant
);

	// ------------------------------------------------------------
	// grant search
	// ------------------------------------------------------------
	logic [1:0] last_ff; // port granted last
	logic [1:0] idx; // candidate port

	// search starts one past the last winner so every port gets a turn
	always_comb begin
		idx = 2'h0;
		arb_port.gnt_vld = 1'b0;
		arb_port.gnt_idx = 2'h0;
		for (int k = 1; k <= 4; k++) begin
			idx = 2'(last_ff + 2'(k));
			if (!arb_port.gnt_vld && arb_port.req[idx]) begin
				arb_port.gnt_vld = 1'b1;
				arb_port.gnt_idx = idx;
			end
		end
	end

	// pointer moves only when the grant is used
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			last_ff <= 2'h3;
		end else if (arb_port.take) begin
			last_ff <= arb_port.gnt_idx;
		end
	end

endmodule // fwd_rr_arb

// [rtl/fwd_engine_top.sv]
// module: register file and the two packet forwarding engines
`timescale 1ns/10ps
// What this block does
// [RL1] engine moves buffered packets to its transmitter
// [RL2] buffer packet availability watched every cycle
// [RL3] disabled ports forward nothing
// [RL4] each buffer mapped to exactly one transmitter
// [RL5] two engines run independently
// [RL6] best effort forwards ready packets round robin
// [RL7] best effort keeps per channel frame packets
// [RL8] best effort passes data types unchanged
// [RL9] round robin enable bit per transmitter
// [RL10] synchronized order: sync packets, lines, ports 0-3
// [RL11] sensor index equals receive port index
// [RL12] any port subset may be synchronized
// [RL13] sources arrive aligned with identical parameters
// [RL14] on sync failure discard until frame start
// [RL15] synced status and read-cleared lost flag
// [RL16] mode field selects basic, interleave, concatenate
// [RL17] host clears round robin before enabling sync
// [RL18] basic: all starts, interleaved lines, all ends
// [RL19] basic keeps each port's channel identifier
// [RL20] interleave: only first port's start/end sent
// [RL21] concatenate joins lines, lowest port's channel
// [RL22] packet read only when wholly buffered
// [RL23] sync status zero when sync mode off
// [RL24] distinct mode codes, round robin when off
module fwd_engine_top #(
	parameter int WC_W = 16 // word count width
) (
	input wire logic I_CLK_SYS, // device clock
	input wire logic I_RST_N, // asynchronous reset, active low
	input wire logic [7:0] I_REG_ADDR, // register offset
	input wire logic [7:0] I_REG_WDATA, // register write data
	input wire logic I_REG_WR, // write strobe
	input wire logic I_REG_RD, // read strobe
	output logic [7:0] O_REG_RDATA, // read data, one cycle after the strobe
	input wire logic [3:0] I_BUF_PKT_RDY, // whole head packet present
	input wire logic [3:0][1:0] I_BUF_KIND, // head packet kind
	input wire logic [3:0][1:0] I_BUF_VC, // head packet channel
	input wire logic [3:0][WC_W-1:0] I_BUF_WC, // head packet word count
	input wire logic [3:0][7:0] I_BUF_DATA, // head payload byte
	output logic [3:0] O_BUF_RD, // take one payload byte
	output logic [3:0] O_BUF_NEXT, // release the head packet
	input wire logic [1:0] I_TX_RDY, // transmitter accepts a beat
	output logic [1:0] O_TX_VLD, // beat valid
	output logic [1:0] O_TX_SOP, // header beat
	output logic [1:0] O_TX_EOP, // last beat of packet
	output logic [1:0] O_TX_HS, // high speed burst in progress
	output logic [1:0][1:0] O_TX_KIND, // packet kind
	output logic [1:0][1:0] O_TX_VC, // packet channel
	output logic [1:0][WC_W-1:0] O_TX_WC, // packet word count
	output logic [1:0][7:0] O_TX_DATA // payload byte
);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (WC_W < 8 || WC_W > 16) begin : g_bad_wc
		$error("WC_W must lie between 8 and 16");
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// lowest member of set at or above from; bit 2 flags a find
	function automatic logic [2:0] first_at(input logic [3:0] set, input logic [2:0] from);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 3; i >= 0; i--) begin
			if (set[i] && (3'(i) >= from)) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction

	// total word count over the ports of a set
	function automatic logic [WC_W-1:0] wc_sum(input logic [3:0] set,
		input logic [3:0][WC_W-1:0] wc);
		logic [WC_W-1:0] s;
		s = '0;
		for (int i = 0; i < 4; i++) begin
			if (set[i]) begin
				s = s + wc[i];
			end
		end
		return s;
	endfunction

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [7:0] map_ff; // forward_port_map_ctl
	logic [7:0] mode_ff; // forward_mode_ctl
	logic [7:0] rdata_ff; // read data
	logic [7:0] stat_w; // status word
	logic rd_stat; // status read, clears lost flags
	logic [1:0] sync_st; // synced per transmitter
	logic [1:0] lost_st; // lost per transmitter
	logic [1:0][3:0] eng_rd; // byte reads per engine
	logic [1:0][3:0] eng_pop; // releases per engine

	assign rd_stat = I_REG_RD && (I_REG_ADDR == fwd_pkg::REG_STAT_ADDR);
	assign O_REG_RDATA = rdata_ff;
	assign O_BUF_RD = eng_rd[0] | eng_rd[1];
	assign O_BUF_NEXT = eng_pop[0] | eng_pop[1];

	// control writes; status is read only
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			map_ff <= fwd_pkg::MAP_RST;
			mode_ff <= fwd_pkg::MODE_RST;
		end else if (I_REG_WR) begin
			if (I_REG_ADDR == fwd_pkg::REG_MAP_ADDR) begin
				map_ff <= I_REG_WDATA; // see RL3 see RL4
			end
			if (I_REG_ADDR == fwd_pkg::REG_MODE_ADDR) begin
				mode_ff <= I_REG_WDATA; // see RL9 see RL16
			end
		end
	end

	// status word assembly
	always_comb begin
		stat_w = 8'h00;
		stat_w[fwd_pkg::STAT_SYNC_LSB +: 2] = sync_st;
		stat_w[fwd_pkg::STAT_LOST_LSB +: 2] = lost_st; // see RL15
	end

	// read mux; unmapped offsets read zero
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rdata_ff <= 8'h00;
		end else if (I_REG_RD) begin
			unique case (I_REG_ADDR)
				fwd_pkg::REG_MAP_ADDR: rdata_ff <= map_ff;
				fwd_pkg::REG_MODE_ADDR: rdata_ff <= mode_ff;
				fwd_pkg::REG_STAT_ADDR: rdata_ff <= stat_w;
				default: rdata_ff <= 8'h00;
			endcase
		end
	end

	// a buffer belongs to one engine, so reads never collide
	AST_ONE_OWNER: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see RL4
		(eng_rd[0] & eng_rd[1]) == 4'h0)
		else $error("two engines read one buffer");

	// ------------------------------------------------------------
	// forwarding engines, one per transmitter
	// ------------------------------------------------------------
	for (genvar t = 0; t < 2; t++) begin : g_tx // see RL5
		fwd_arb_if arb_if ();
		fwd_pkg::sync_mode_e mode; // synchronized mode of this engine
		fwd_pkg::eng_state_e st_ff; // scheduler state
		fwd_pkg::pkt_kind_e phase_ff; // kind of the running round
		fwd_pkg::pkt_kind_e hk; // head kind of expected port
		fwd_pkg::pkt_kind_e rk; // kind of the round being taken
		logic rr_en, sync_en, cat_m, merge_m, can_out;
		logic [3:0] own, dis, sset; // ownership and active set
		logic [2:0] first3, nexp3, ncur3; // port searches
		logic all_rdy, all_fs, same_k, ok, at_start, go, lose, rr_go;
		logic start, emit, short_p, last_b, hunt_done;
		logic [1:0] sel; // port taken
		logic [3:0] pop_v, rd_v; // release and read strobes
		logic [WC_W-1:0] sum_w; // concatenated word count
		logic [1:0] cur_ff; // port being streamed
		logic [1:0] exp_ff; // next port in synchronized order
		logic [WC_W-1:0] left_ff; // bytes left of current port
		logic cat_ff; // packet is a concatenated line
		logic frame_ff; // inside a synchronized frame
		logic synced_ff, lost_ff, hs_ff;
		logic vld_ff, sop_ff, eop_ff;
		logic [1:0] kind_ff, vc_ff;
		logic [WC_W-1:0] wc_ff;
		logic [7:0] data_ff;

		fwd_rr_arb u_arb (
			.i_clk(I_CLK_SYS),
			.i_rst_n(I_RST_N),
			.arb_port(arb_if)
		);

		// mode decode; off means round robin when enabled
		assign mode = fwd_pkg::sync_mode_e'(mode_ff[fwd_pkg::SYNC_LSB + 2 * t +: 2]);
		assign rr_en = mode_ff[fwd_pkg::RR_LSB + t]; // see RL9
		assign sync_en = (mode != fwd_pkg::SYNC_OFF); // see RL24
		assign cat_m = (mode == fwd_pkg::SYNC_CAT);
		assign merge_m = (mode == fwd_pkg::SYNC_ILV) || cat_m; // one start/end per frame
		assign dis = map_ff[fwd_pkg::DIS_LSB +: 4];
		assign can_out = !vld_ff || I_TX_RDY[t];

		// ports mapped here and not disabled
		always_comb begin
			for (int p = 0; p < 4; p++) begin
				own[p] = (map_ff[fwd_pkg::MAP_LSB + p] == 1'(t)); // see RL4
			end
		end
		assign sset = own & ~dis; // see RL3 see RL12

		// round robin requests: any active port holding a whole packet
		assign arb_if.req = (!sync_en && rr_en) ? (sset & I_BUF_PKT_RDY) : 4'h0; // see RL6
		assign arb_if.take = rr_go;

		// scheduling decision, evaluated every cycle
		always_comb begin
			first3 = first_at(sset, 3'h0);
			nexp3 = first_at(sset, {1'b0, exp_ff} + 3'h1);
			ncur3 = first_at(sset, {1'b0, cur_ff} + 3'h1);
			hk = fwd_pkg::pkt_kind_e'(I_BUF_KIND[exp_ff]); // see RL11
			at_start = (exp_ff == first3[1:0]);
			rk = at_start ? hk : phase_ff;
			all_rdy = (sset != 4'h0) && ((sset & ~I_BUF_PKT_RDY) == 4'h0); // see RL2
			all_fs = 1'b1;
			same_k = 1'b1;
			for (int p = 0; p < 4; p++) begin
				if (sset[p] && (I_BUF_KIND[p] != fwd_pkg::PK_FS)) begin
					all_fs = 1'b0;
				end
				if (sset[p] && (I_BUF_KIND[p] != hk)) begin
					same_k = 1'b0;
				end
			end
			// a round opens with start, line or end; the rest must match it
			if (at_start) begin
				ok = frame_ff ? (hk == fwd_pkg::PK_LINE || hk == fwd_pkg::PK_FE)
					: (hk == fwd_pkg::PK_FS); // see RL10
			end else begin
				ok = (hk == phase_ff);
			end
			if (cat_m) begin
				ok = ok && same_k; // see RL21
			end
			go = (st_ff == fwd_pkg::ST_IDLE) && sync_en && synced_ff && can_out
				&& (cat_m ? all_rdy : I_BUF_PKT_RDY[exp_ff]); // see RL22
			lose = go && !ok; // see RL14
			rr_go = (st_ff == fwd_pkg::ST_IDLE) && !sync_en && rr_en
				&& arb_if.gnt_vld && can_out; // see RL6 see RL24
			start = (go && ok) || rr_go;
			sel = rr_go ? arb_if.gnt_idx : exp_ff;
			short_p = !I_BUF_KIND[sel][1] || (I_BUF_WC[sel] == '0);
			// merged modes send only the first port's start and end
			emit = start && !(sync_en && merge_m && short_p && !at_start); // see RL20
			sum_w = wc_sum(sset, I_BUF_WC);
			// identical line sizes let the last port's last byte end the packet
			last_b = (left_ff == WC_W'(1)) && !(cat_ff && ncur3[2]); // see RL13
			hunt_done = (st_ff == fwd_pkg::ST_HUNT) && sync_en && all_rdy && all_fs;
			pop_v = 4'h0;
			rd_v = 4'h0;
			if (start && short_p) begin
				pop_v = (sync_en && cat_m) ? sset : (4'h1 << sel); // see RL21
			end
			if ((st_ff == fwd_pkg::ST_DATA) && can_out) begin
				rd_v[cur_ff] = (left_ff != '0);
				pop_v[cur_ff] = (left_ff <= WC_W'(1));
			end
			// while hunting, drop every head that is not a frame start
			if (st_ff == fwd_pkg::ST_HUNT) begin
				for (int p = 0; p < 4; p++) begin
					if (sset[p] && I_BUF_PKT_RDY[p] && (I_BUF_KIND[p] != fwd_pkg::PK_FS)) begin
						pop_v[p] = 1'b1; // see RL14
					end
				end
			end
		end
		assign eng_rd[t] = rd_v;
		assign eng_pop[t] = pop_v;

		// scheduler state, stream pointers and synchronized order
		always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
			if (!I_RST_N) begin
				st_ff <= fwd_pkg::ST_IDLE;
				cur_ff <= 2'h0;
				exp_ff <= 2'h0;
				left_ff <= '0;
				cat_ff <= 1'b0;
				frame_ff <= 1'b0;
				phase_ff <= fwd_pkg::PK_FS;
			end else begin
				unique case (st_ff)
					fwd_pkg::ST_IDLE: begin
						if (lose || (sync_en && !synced_ff)) begin
							st_ff <= fwd_pkg::ST_HUNT; // see RL14
						end else if (start) begin
							cur_ff <= sel;
							cat_ff <= sync_en && cat_m;
							left_ff <= I_BUF_WC[sel];
							if (!short_p) begin
								st_ff <= fwd_pkg::ST_DATA;
							end
							if (sync_en) begin
								phase_ff <= rk;
								// round done: frame start opens, frame end closes
								if (cat_m || !nexp3[2]) begin
									exp_ff <= first3[1:0]; // see RL18
									if (rk == fwd_pkg::PK_FS) begin
										frame_ff <= 1'b1;
									end
									if (rk == fwd_pkg::PK_FE) begin
										frame_ff <= 1'b0;
									end
								end else begin
									exp_ff <= nexp3[1:0]; // see RL10
								end
							end
						end
					end
					fwd_pkg::ST_DATA: begin
						if (can_out && (left_ff <= WC_W'(1))) begin
							// concatenation continues with the next port's line
							if (cat_ff && ncur3[2]) begin
								cur_ff <= ncur3[1:0]; // see RL21
								left_ff <= I_BUF_WC[ncur3[1:0]];
							end else begin
								st_ff <= fwd_pkg::ST_IDLE;
							end
						end else if (can_out) begin
							left_ff <= left_ff - WC_W'(1);
						end
					end
					fwd_pkg::ST_HUNT: begin
						if (!sync_en) begin
							st_ff <= fwd_pkg::ST_IDLE;
						end else if (hunt_done) begin
							st_ff <= fwd_pkg::ST_IDLE;
							exp_ff <= first3[1:0];
							frame_ff <= 1'b0;
							phase_ff <= fwd_pkg::PK_FS;
						end
					end
					default: st_ff <= fwd_pkg::ST_IDLE;
				endcase
			end
		end

		// synced status and sticky lost flag; a loss beats a clearing read
		always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
			if (!I_RST_N) begin
				synced_ff <= 1'b0;
				lost_ff <= 1'b0;
			end else begin
				if (!sync_en || lose) begin
					synced_ff <= 1'b0; // see RL23
				end else if (hunt_done) begin
					synced_ff <= 1'b1;
				end
				if (lose) begin
					lost_ff <= 1'b1; // see RL15
				end else if (rd_stat) begin
					lost_ff <= 1'b0;
				end
			end
		end
		assign sync_st[t] = synced_ff && sync_en; // see RL23
		assign lost_st[t] = lost_ff;

		// output beat: header on take, one byte per beat while streaming
		always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
			if (!I_RST_N) begin
				vld_ff <= 1'b0;
				sop_ff <= 1'b0;
				eop_ff <= 1'b0;
				kind_ff <= 2'h0;
				vc_ff <= 2'h0;
				wc_ff <= '0;
				data_ff <= 8'h00;
			end else if (can_out) begin
				vld_ff <= 1'b0;
				sop_ff <= 1'b0;
				eop_ff <= 1'b0;
				if (emit) begin
					vld_ff <= 1'b1;
					sop_ff <= 1'b1;
					eop_ff <= short_p;
					kind_ff <= I_BUF_KIND[sel]; // see RL7 see RL8
					vc_ff <= I_BUF_VC[sel]; // see RL19
					wc_ff <= (sync_en && cat_m && !short_p) ? sum_w : I_BUF_WC[sel];
					data_ff <= 8'h00;
				end else if (rd_v != 4'h0) begin
					vld_ff <= 1'b1;
					eop_ff <= last_b;
					data_ff <= I_BUF_DATA[cur_ff];
				end
			end
		end

		// high speed from the header until the last beat is taken
		always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
			if (!I_RST_N) begin
				hs_ff <= 1'b0;
			end else begin
				hs_ff <= (st_ff == fwd_pkg::ST_DATA) || emit || (vld_ff && !I_TX_RDY[t]); // see RL1
			end
		end

		assign O_TX_VLD[t] = vld_ff;
		assign O_TX_SOP[t] = sop_ff;
		assign O_TX_EOP[t] = eop_ff;
		assign O_TX_HS[t] = hs_ff;
		assign O_TX_KIND[t] = kind_ff;
		assign O_TX_VC[t] = vc_ff;
		assign O_TX_WC[t] = wc_ff;
		assign O_TX_DATA[t] = data_ff;

		// ------------------------------------------------------------
		// checks
		// ------------------------------------------------------------
		sequence s_loss;
			lose ##1 (st_ff == fwd_pkg::ST_HUNT);
		endsequence

		AST_WHOLE_PKT: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see RL22
			start |-> I_BUF_PKT_RDY[sel])
			else $error("packet taken before it was whole");
		AST_ACTIVE_PORT: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see RL3
			start |-> (own[sel] && !dis[sel]))
			else $error("packet taken from a foreign or disabled port");
		AST_RR_GATE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see RL9
			arb_if.take |-> (mode_ff[fwd_pkg::RR_LSB + t] && (mode == fwd_pkg::SYNC_OFF)))
			else $error("round robin grant used outside round robin mode");
		AST_SYNC_ZERO: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see RL23
			(mode == fwd_pkg::SYNC_OFF) |=> !sync_st[t])
			else $error("sync status set with sync mode off");
		AST_HUNT_QUIET: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see RL14
			s_loss |-> (lost_ff && !synced_ff && (rd_v == 4'h0)))
			else $error("loss of sync did not stop forwarding");
		AST_LOST_CLR: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see RL15
			(rd_stat && !lose) |=> !lost_st[t])
			else $error("lost flag survived a status read");
		AST_HS_SOP: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see RL1
			(vld_ff && sop_ff) |-> hs_ff)
			else $error("header beat outside high speed");
		AST_MERGE_DROP: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see RL20
			(start && sync_en && merge_m && short_p && !at_start) |=> !vld_ff)
			else $error("extra start or end forwarded in merged mode");
		AST_CAT_HDR: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see RL21
			(emit && cat_m && sync_en && !short_p) ##1 (st_ff == fwd_pkg::ST_DATA)
			|-> (wc_ff == $past(sum_w)) && (vc_ff == $past(I_BUF_VC[first3[1:0]])))
			else $error("concatenated header wrong");
	end

endmodule // fwd_engine_top

// [tb/csi_rx_model.sv]
// model: downstream csi-2 receiver with random back pressure and framing check
`timescale 1ns/10ps
module csi_rx_model #(
	parameter int W = 16 // word count width
) (
	input wire logic i_clk, // device clock
	input wire logic i_rst_n, // active low reset
	input wire logic i_stall, // allow random stalls
	input wire logic [1:0] i_vld, // beat valid per transmitter
	input wire logic [1:0] i_sop, // header beat
	input wire logic [1:0] i_eop, // last beat
	input wire logic [1:0][W-1:0] i_wc, // header word count
	output logic [1:0] o_rdy, // accept per transmitter
	output int o_bad // framing faults seen
);
	int left[2]; // payload beats still owed per transmitter
	initial begin
		o_rdy = 2'b11;
		o_bad = 0;
	end
	// ready moves only between sampling edges
	always @(negedge i_clk) begin
		o_rdy <= i_stall ? 2'($urandom) : 2'b11;
	end
	// header then exactly wc bytes, eop on the last one
	always @(posedge i_clk) begin
		for (int t = 0; t < 2; t++) begin
			if (i_rst_n && i_vld[t] && o_rdy[t]) begin
				left[t] = i_sop[t] ? int'(i_wc[t]) : left[t] - 1;
				if (i_eop[t] != (left[t] == 0)) o_bad++;
			end
		end
	end
endmodule // csi_rx_model

// [tb/tb_top.sv]
// testbench: registers, round robin and synchronized forwarding
`timescale 1ns/10ps
module tb_top;
	// ----------------------------------------
	// stimulus state
	// ----------------------------------------
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, stall = 1;
	logic [7:0] adr = '0, wd = '0, rdata;
	logic [3:0] brdy = '0, brd, bnx, rd_ff = '0, nx_ff = '0;
	logic [3:0][1:0] bk = '0, bv = '0;
	logic [3:0][15:0] bw = '0;
	logic [3:0][7:0] bd = '0; // payload byte counters
	logic [1:0] trdy, tvld, tsop, teop, ths;
	logic [1:0][7:0] tdat; // payload bytes as sent
	logic [3:0][7:0] eb = '0; // next byte each buffer should hand out
	logic [1:0][1:0] tk, tv;
	logic [1:0][15:0] tw;
	logic [15:0] w;
	logic [1:0] v;
	int n_errors = 0, checks = 0, bad, nhs = 0;
	typedef struct packed {logic [1:0] k; logic [1:0] v; logic [15:0] w;} pkt_s;
	pkt_s pq[4][$]; // per port packet queues
	logic [12:0] obs[$], ex[$]; // seen and expected headers
	logic [7:0] dq[$], dx[$]; // seen and expected payload on transmitter 0
	initial forever #12.5 clk = ~clk;
	fwd_engine_top i_fwd_engine_top (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_REG_ADDR(adr),
		.I_REG_WDATA(wd), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
		.I_BUF_PKT_RDY(brdy), .I_BUF_KIND(bk), .I_BUF_VC(bv), .I_BUF_WC(bw),
		.I_BUF_DATA(bd), .O_BUF_RD(brd), .O_BUF_NEXT(bnx), .I_TX_RDY(trdy),
		.O_TX_VLD(tvld), .O_TX_SOP(tsop), .O_TX_EOP(teop), .O_TX_HS(ths), .O_TX_KIND(tk),
		.O_TX_VC(tv), .O_TX_WC(tw), .O_TX_DATA(tdat));
	csi_rx_model i_csi_rx_model (.i_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_vld(tvld),
		.i_sop(tsop), .i_eop(teop), .i_wc(tw), .o_rdy(trdy), .o_bad(bad));
	// ----------------------------------------
	// video buffer model and header monitor
	// ----------------------------------------
	always @(posedge clk) begin
		rd_ff <= brd;
		nx_ff <= bnx;
		for (int t = 0; t < 2; t++) begin
			if (tvld[t] && trdy[t] && tsop[t]) obs.push_back({1'(t), tk[t], tv[t], tw[t][7:0]});
			if (t == 0 && tvld[t] && trdy[t] && !tsop[t]) dq.push_back(tdat[t]);
			if (tvld[t] && !ths[t]) nhs++;
		end
	end
	// released heads leave, next head shows on the falling edge
	always @(negedge clk) begin
		for (int p = 0; p < 4; p++) begin
			if (nx_ff[p] && pq[p].size() > 0) pq[p].pop_front();
			if (rd_ff[p]) bd[p] <= bd[p] + 8'h01;
			brdy[p] <= pq[p].size() > 0;
			if (pq[p].size() > 0) {bk[p], bv[p], bw[p]} <= pq[p][0];
		end
	end
	// ----------------------------------------
	// tasks and expectation functions
	// ----------------------------------------
	task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic reg_io(input logic we, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = we;
		rd = !we;
		adr = a;
		wd = d;
		@(negedge clk);
		wr = 0;
		rd = 0;
	endtask
	task automatic rdck(input logic [7:0] a, input logic [7:0] exp);
		reg_io(0, a, 8'h00);
		check("rdata", 16'(rdata), 16'(exp));
	endtask
	function automatic logic [12:0] mk(logic t, logic [1:0] k, logic [1:0] c, logic [15:0] n);
		return {t, k, c, n[7:0]};
	endfunction
	task automatic push(int p, logic [1:0] k, logic [1:0] c, logic [15:0] n);
		pq[p].push_back({k, c, n});
	endtask
	// one frame per port: start, one line, end; starts on ports 1..3 may be left out
	task automatic frame(logic [15:0] n, logic skip);
		for (int p = 0; p < 4; p++) begin
			if (!skip || p == 0) push(p, fwd_pkg::PK_FS, 2'(p), 0);
			push(p, fwd_pkg::PK_LINE, 2'(p), n);
			push(p, fwd_pkg::PK_FE, 2'(p), 0);
		end
	endtask
	// next n payload bytes of a port: each buffer counts up from zero as it is read
	function automatic void exp_bytes(int p, logic [15:0] n);
		for (int i = 0; i < n; i++) begin
			dx.push_back(eb[p]);
			eb[p] = eb[p] + 8'h01;
		end
	endfunction
	// expected headers on transmitter 0 for one synchronized frame
	function automatic void exp_sync(logic [1:0] m, logic [15:0] n);
		for (int p = 0; p < 4; p++) if (p == 0 || m == 2'b01) ex.push_back(mk(0, 2'b00, 2'(p), 0));
		for (int p = 0; p < 4; p++) exp_bytes(p, n);
		if (m == 2'b11) ex.push_back(mk(0, 2'b10, 2'b00, n * 4));
		else for (int p = 0; p < 4; p++) ex.push_back(mk(0, 2'b10, 2'(p), n));
		for (int p = 0; p < 4; p++) if (p == 0 || m == 2'b01) ex.push_back(mk(0, 2'b01, 2'(p), 0));
	endfunction
	task automatic fin(string nm);
		int n;
		n = 0;
		while (obs.size() < ex.size() && n < 3000) begin
			@(negedge clk);
			n++;
		end
		repeat (60) @(negedge clk);
		check({nm, " count"}, 16'(obs.size()), 16'(ex.size()));
		foreach (ex[i]) begin
			if (i < obs.size()) check(nm, 16'(obs[i]), 16'(ex[i]));
		end
		check({nm, " bytes"}, 16'(dq.size()), 16'(dx.size()));
		foreach (dx[i]) begin
			if (i < dq.size()) check({nm, " byte"}, 16'(dq[i]), 16'(dx[i]));
		end
		check({nm, " hs idle"}, 16'(ths), 16'h0000);
		obs.delete();
		ex.delete();
		dq.delete();
		dx.delete();
		$display("done %s", nm);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------
	// watchdog and main sequence
	// ----------------------------------------
	initial begin
		#1_000_000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h8333_5823));
		repeat (16) @(negedge clk);
		rst_n = 1;
		rdck(8'h20, fwd_pkg::MAP_RST);
		rdck(8'h21, fwd_pkg::MODE_RST);
		rdck(8'h22, 8'h00);
		rdck(8'h7f, 8'h00);
		// round robin resumes after the last granted port, port 2 disabled
		reg_io(1, 8'h20, 8'h04);
		rdck(8'h20, 8'h04);
		push(0, fwd_pkg::PK_FS, 0, 0);
		ex = {mk(0, 2'b00, 2'b00, 0)};
		fin("rr first");
		w = 16'($urandom_range(1, 4));
		v = 2'($urandom);
		push(1, fwd_pkg::PK_FS, 1, 0);
		push(1, fwd_pkg::PK_LINE, 1, w);
		push(2, fwd_pkg::PK_FS, 2, 0);
		push(3, fwd_pkg::PK_OTHER, v, w);
		ex = {mk(0, 2'b00, 2'b01, 0), mk(0, 2'b11, v, w), mk(0, 2'b10, 2'b01, w)};
		exp_bytes(3, w);
		exp_bytes(1, w);
		fin("rr order");
		pq[2].delete();
		// port 3 moved to transmitter 1 whose round robin is off
		reg_io(1, 8'h20, 8'h80);
		reg_io(1, 8'h21, 8'h40);
		push(0, fwd_pkg::PK_FS, 0, 0);
		push(3, fwd_pkg::PK_FS, 3, 0);
		ex = {mk(0, 2'b00, 2'b00, 0)};
		fin("rr off");
		reg_io(1, 8'h21, 8'hc0);
		ex = {mk(1, 2'b00, 2'b11, 0)};
		fin("map tx1");
		// each synchronized mode on all four ports, host order kept
		for (int m = 1; m < 4; m++) begin
			stall = m[0];
			reg_io(1, 8'h21, 8'h00);
			reg_io(1, 8'h20, 8'h00);
			reg_io(1, 8'h21, 8'(m << 2));
			w = 16'($urandom_range(1, 3));
			frame(w, 1'b0);
			exp_sync(2'(m), w);
			fin("sync mode");
			rdck(8'h22, 8'h01);
		end
		// line where a start is due: loss, discard, then resync
		push(0, fwd_pkg::PK_LINE, 0, w);
		for (int p = 1; p < 4; p++) push(p, fwd_pkg::PK_FS, 2'(p), 0);
		repeat (40) @(negedge clk);
		rdck(8'h22, 8'h04);
		rdck(8'h22, 8'h00);
		frame(w, 1'b1);
		exp_sync(2'b11, w);
		fin("resync");
		check("framing", 16'(bad), 16'h0000);
		check("hs", 16'(nhs), 16'h0000);
		report_and_stop();
	end
endmodule // tb_top
